/* motor_ctrl_pkg.sv */
// Shared constants of the six-step motor controller: register map, field
// positions, reset values and timing counts for a 20 MHz system clock.
package motor_ctrl_pkg;

    // Clock and timing
    localparam int          SYS_CLK_HZ        = 20_000_000;
    localparam int          CLK_PERIOD_NS     = 50;
    localparam int          PWM_FREQ_HZ       = 25_000;
    localparam int          PWM_PERIOD_CYC    = SYS_CLK_HZ / PWM_FREQ_HZ;
    localparam int          PWM_MIN_FREQ_HZ   = 20_000;
    localparam int          PWM_MAX_FREQ_HZ   = 30_000;
    localparam int          FB_MIN_LOW_US     = 50;
    // Strictly above the minimum, so one cycle more than the exact figure
    localparam int          FB_MIN_LOW_CYC    = (FB_MIN_LOW_US * 1000) / CLK_PERIOD_NS + 1;

    // Register port geometry
    localparam int          ADDR_W            = 4;
    localparam int          DATA_W            = 16;
    localparam int          SPEED_W           = 8;
    localparam int          CUR_W             = 8;

    // Register byte offsets
    localparam logic [3:0]  SPEED_CMD_OFS     = 4'h0;
    localparam logic [3:0]  CUR_LIMIT_OFS     = 4'h4;
    localparam logic [3:0]  LOW_TIME_OFS      = 4'h8;
    localparam logic [3:0]  STATUS_OFS        = 4'hC;

    // Reset values
    localparam logic [7:0]  SPEED_CMD_RST     = 8'h00;
    localparam logic [7:0]  CUR_LIMIT_RST     = 8'h80;
    localparam logic [15:0] LOW_TIME_RST      = 16'h4E20;

    // Status field positions
    localparam int          ST_CODE_LSB       = 0;
    localparam int          ST_VALID_BIT      = 3;
    localparam int          ST_OVER_BIT       = 4;
    localparam int          ST_BRAKE_BIT      = 5;
    localparam int          ST_RUN_BIT        = 6;

    // Commutation modes
    typedef enum logic [1:0] {
        DRV_OFF,
        DRV_BRAKE,
        DRV_RUN
    } drive_mode_t;

endpackage

/* commutation_if.sv */
// Carrier between the controller top and its sensor-code decoder.
// Assumes one clock domain; the decoder is purely combinational.
`timescale 1ns/1ps
interface commutation_if;
    logic [2:0] code;
    logic       dir_cw;
    logic [2:0] high_sel;
    logic [2:0] low_sel;
    logic       valid;

    modport dec  (input code, dir_cw, output high_sel, low_sel, valid);
    modport user (output code, dir_cw, input high_sel, low_sel, valid);
endinterface

/* commutation_decode.sv */
// Six-step decoder: rotor sensor code and direction to phase selection.
// Assumes the code is already synchronised; output is combinational.
`timescale 1ns/1ps
module commutation_decode (
    // Code in, phase selection out
    commutation_if.dec cif
);

    // One-hot low and high phase for clockwise order (U=bit0, V=bit1, W=bit2)
    function automatic logic [5:0] cw_step(input logic [2:0] c);
        case (c)
            3'h5:    cw_step = {3'h2, 3'h1};
            3'h4:    cw_step = {3'h4, 3'h1};
            3'h6:    cw_step = {3'h4, 3'h2};
            3'h2:    cw_step = {3'h1, 3'h2};
            3'h3:    cw_step = {3'h1, 3'h4};
            3'h1:    cw_step = {3'h2, 3'h4};
            default: cw_step = 6'h00;
        endcase
    endfunction

    wire [5:0] step_w = cw_step(cif.code);

    // Counter-clockwise swaps the roles of the two conducting phases
    assign cif.valid    = (cif.code != 3'h0) && (cif.code != 3'h7);
    assign cif.high_sel = cif.dir_cw ? step_w[2:0] : step_w[5:3];
    assign cif.low_sel  = cif.dir_cw ? step_w[5:3] : step_w[2:0];

endmodule

/* motor_ctrl_top.sv */
// Six-step brushless motor commutation controller with low-side PWM,
// current cut-off, brake, and speed feedback pulse.
// Assumes pins are asynchronous to SYS_CLK_I; register port on the same clock.
`timescale 1ns/1ps
module motor_ctrl_top #(
    parameter int PWM_PERIOD = motor_ctrl_pkg::PWM_PERIOD_CYC
) (
    // Clock and reset
    input  wire logic        SYS_CLK_I,
    input  wire logic        SRST_I,
    // Register port
    input  wire logic [3:0]  REG_ADDR_I,
    input  wire logic [15:0] REG_WDATA_I,
    input  wire logic        REG_WR_I,
    input  wire logic        REG_RD_I,
    output logic      [15:0] REG_RDATA_O,
    // Command pins
    input  wire logic        RUN_STOP_I,
    input  wire logic        DIRECTION_SELECT_I,
    input  wire logic        BRAKE_N_I,
    // Sensor pins
    input  wire logic [2:0]  ROTOR_SENSOR_POSITIVE_I,
    input  wire logic [2:0]  ROTOR_SENSOR_NEGATIVE_I,
    input  wire logic [7:0]  SENSED_CURRENT_VOLTAGE_I,
    // Drive outputs
    output logic      [2:0]  HIGH_SIDE_O,
    output logic      [2:0]  LOW_SIDE_O,
    output logic             SPEED_FEEDBACK_PULSE_O
);

    localparam int SYNC_W = 17;
    localparam int FB_MIN = motor_ctrl_pkg::FB_MIN_LOW_CYC;

    // Carrier must stay inside the 20 to 30 kHz band and fit the 10-bit counter
    if (PWM_PERIOD < motor_ctrl_pkg::SYS_CLK_HZ / motor_ctrl_pkg::PWM_MAX_FREQ_HZ ||
        PWM_PERIOD > motor_ctrl_pkg::SYS_CLK_HZ / motor_ctrl_pkg::PWM_MIN_FREQ_HZ ||
        PWM_PERIOD > 1023) begin : g_period_check
        $error("PWM_PERIOD outside the usable carrier band");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser

    logic [SYNC_W-1:0] meta_r;
    logic [SYNC_W-1:0] sync_r;
    wire  [SYNC_W-1:0] pins_w = {SENSED_CURRENT_VOLTAGE_I, ROTOR_SENSOR_NEGATIVE_I,
                                 ROTOR_SENSOR_POSITIVE_I, BRAKE_N_I, DIRECTION_SELECT_I,
                                 RUN_STOP_I};

    // Idle pin levels; brake input idles high, so reset never fakes a brake
    localparam logic [SYNC_W-1:0] SYNC_IDLE = 17'h00004;

    // Two stages; only the second stage is read by logic
    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            meta_r <= SYNC_IDLE;
            sync_r <= SYNC_IDLE;
        end else begin
            meta_r <= pins_w;
            sync_r <= meta_r;
        end
    end

    wire       run_s     = sync_r[0];
    wire       dir_s     = sync_r[1];
    wire       brake_act = ~sync_r[2];
    wire [2:0] pos_s     = sync_r[5:3];
    wire [2:0] neg_s     = sync_r[8:6];
    wire [7:0] cur_s     = sync_r[16:9];

    ////////////////////////////////////////////////////////////////////////////////
    // Register file

    logic [7:0]  speed_cmd_r;
    logic [7:0]  cur_limit_r;
    logic [15:0] low_time_r;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic [15:0] status_w;
    logic        over_w;

    wire wr_speed = REG_WR_I && (REG_ADDR_I == motor_ctrl_pkg::SPEED_CMD_OFS);
    wire wr_limit = REG_WR_I && (REG_ADDR_I == motor_ctrl_pkg::CUR_LIMIT_OFS);
    wire wr_low   = REG_WR_I && (REG_ADDR_I == motor_ctrl_pkg::LOW_TIME_OFS);

    // Read mux; unmapped offsets read zero
    always_comb begin
        rdata_nxt = 16'h0000;
        if (REG_RD_I) begin
            case (REG_ADDR_I)
                motor_ctrl_pkg::SPEED_CMD_OFS: rdata_nxt = {8'h00, speed_cmd_r};
                motor_ctrl_pkg::CUR_LIMIT_OFS: rdata_nxt = {8'h00, cur_limit_r};
                motor_ctrl_pkg::LOW_TIME_OFS:  rdata_nxt = low_time_r;
                motor_ctrl_pkg::STATUS_OFS:    rdata_nxt = status_w;
                default:                       rdata_nxt = 16'h0000;
            endcase
        end
    end

    // Writes and the one-cycle read answer
    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            speed_cmd_r <= motor_ctrl_pkg::SPEED_CMD_RST;
            cur_limit_r <= motor_ctrl_pkg::CUR_LIMIT_RST;
            low_time_r  <= motor_ctrl_pkg::LOW_TIME_RST;
            rdata_r     <= 16'h0000;
        end else begin
            if (wr_speed) speed_cmd_r <= REG_WDATA_I[7:0];
            if (wr_limit) cur_limit_r <= REG_WDATA_I[7:0];
            if (wr_low)   low_time_r  <= REG_WDATA_I;
            rdata_r <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sensor decode

    commutation_if cif ();
    assign cif.code   = pos_s & ~neg_s; // Asserted when positive leg exceeds negative
    assign cif.dir_cw = dir_s;

    commutation_decode u_decode (
        .cif (cif)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Low-side modulation

    logic [9:0] pwm_cnt_r;

    // Duty threshold scaled from the 8-bit command; full scale gives 255/256 of the period, four cycles short at 800
    function automatic logic [9:0] pwm_compare(input logic [7:0] lvl, input logic [9:0] per);
        logic [17:0] prod;
        prod = lvl * per;
        pwm_compare = prod[17:8];
    endfunction

    wire [9:0] period_w = 10'(PWM_PERIOD);
    wire       pwm_on   = pwm_cnt_r < pwm_compare(speed_cmd_r, period_w);
    assign over_w = cur_s > cur_limit_r;

    // Free-running carrier counter
    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I || pwm_cnt_r == period_w - 10'h001) pwm_cnt_r <= 10'h000;
        else pwm_cnt_r <= pwm_cnt_r + 10'h001;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Drive selection

    motor_ctrl_pkg::drive_mode_t mode_w;
    logic [2:0] high_nxt;
    logic [2:0] low_nxt;

    // Brake first, then stop, then invalid code
    assign mode_w = brake_act ? motor_ctrl_pkg::DRV_BRAKE :
                    (!run_s || !cif.valid) ? motor_ctrl_pkg::DRV_OFF :
                    motor_ctrl_pkg::DRV_RUN;

    always_comb begin
        high_nxt = 3'h0;
        low_nxt  = 3'h0;
        case (mode_w)
            motor_ctrl_pkg::DRV_BRAKE: low_nxt = 3'h7;
            motor_ctrl_pkg::DRV_RUN: begin
                high_nxt = cif.high_sel;
                low_nxt  = (pwm_on && !over_w) ? cif.low_sel : 3'h0;
            end
            default: begin
                high_nxt = 3'h0;
                low_nxt  = 3'h0;
            end
        endcase
    end

    // Registered drive avoids glitches on switch gates
    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            HIGH_SIDE_O <= 3'h0;
            LOW_SIDE_O  <= 3'h0;
        end else begin
            HIGH_SIDE_O <= high_nxt;
            LOW_SIDE_O  <= low_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Speed feedback pulse

    logic [2:0]  prev_code_r;
    logic [15:0] low_cnt_r;
    logic        fb_r;

    wire        step_ev   = cif.valid && (cif.code != prev_code_r);
    wire [15:0] eff_low_w = (low_time_r < 16'(FB_MIN)) ? 16'(FB_MIN) : low_time_r;

    // A new transition restarts the low phase; overlapping pulses merge
    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            prev_code_r <= 3'h0;
            low_cnt_r   <= 16'h0000;
            fb_r        <= 1'b1;
        end else begin
            if (cif.valid) prev_code_r <= cif.code;
            if (step_ev) begin
                low_cnt_r <= eff_low_w - 16'h0001;
                fb_r      <= 1'b0;
            end else if (low_cnt_r != 16'h0000) begin
                low_cnt_r <= low_cnt_r - 16'h0001;
            end else begin
                fb_r <= 1'b1;
            end
        end
    end

    assign SPEED_FEEDBACK_PULSE_O = fb_r;
    assign REG_RDATA_O            = rdata_r;

    // Live state for software
    assign status_w = {9'h000, run_s, brake_act, over_w, cif.valid, cif.code};

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    logic [15:0] low_run_r;

    // Length of the current low phase of the feedback pulse
    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I || fb_r) low_run_r <= 16'h0000;
        else if (low_run_r != 16'hFFFF) low_run_r <= low_run_r + 16'h0001;
    end

    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (SRST_I);

    brake_drive_a: assert property (brake_act
        |=> HIGH_SIDE_O == 3'h0 && LOW_SIDE_O == 3'h7)
        else $error("brake did not short the windings");
    brake_priority_a: assert property (brake_act && run_s && cif.valid
        |=> LOW_SIDE_O == 3'h7)
        else $error("brake lost to run state");
    stop_off_a: assert property (!brake_act && !run_s
        |=> HIGH_SIDE_O == 3'h0 && LOW_SIDE_O == 3'h0)
        else $error("switches on while stopped");
    invalid_off_a: assert property (!brake_act && !cif.valid
        |=> HIGH_SIDE_O == 3'h0 && LOW_SIDE_O == 3'h0)
        else $error("drive on with invalid sensor code");
    direction_order_a: assert property (!brake_act && run_s && cif.valid
        |=> HIGH_SIDE_O == $past(cif.high_sel) && $onehot(HIGH_SIDE_O))
        else $error("high side does not follow decoded step");
    step_decode_a: assert property (!brake_act && run_s && cif.valid && pwm_on && !over_w
        |=> LOW_SIDE_O != 3'h0 && (LOW_SIDE_O & HIGH_SIDE_O) == 3'h0)
        else $error("phase pattern broken");
    over_cut_a: assert property (!brake_act && over_w |=> LOW_SIDE_O == 3'h0)
        else $error("low side on above current limit");
    pwm_off_a: assert property (!brake_act && !pwm_on |=> LOW_SIDE_O == 3'h0)
        else $error("low side on in carrier off phase");
    carrier_wrap_a: assert property (pwm_cnt_r == period_w - 10'h001
        |=> pwm_cnt_r == 10'h000)
        else $error("carrier period wrong");
    fb_start_a: assert property (step_ev |=> !fb_r ##1 !fb_r)
        else $error("no feedback pulse on sensor transition");
    fb_min_low_a: assert property ($rose(fb_r) |-> low_run_r >= 16'(FB_MIN))
        else $error("feedback low time too short");

    brake_seen_c:  cover property (brake_act ##1 LOW_SIDE_O == 3'h7);
    pwm_cycle_c:   cover property ($rose(LOW_SIDE_O != 3'h0) ##[1:900] $fell(LOW_SIDE_O != 3'h0));
    over_cut_c:    cover property (run_s && pwm_on && over_w ##1 LOW_SIDE_O == 3'h0);
    fb_pulse_c:    cover property ($fell(fb_r) ##[1:1000] !fb_r);

endmodule

/* hall_motor_model.sv */
// Motor partner: rotor sensor pairs and shunt current level.
// Assumes the bench picks the rotor position and the load.
`timescale 1ns/1ps
module hall_motor_model (
    // Clock
    input  wire logic       clk_i,
    // Position index (6 dead, 7 shorted) and load
    input  wire logic [2:0] sel_i,
    input  wire logic [7:0] load_i,
    // Sensor legs and current
    output logic      [2:0] pos_o,
    output logic      [2:0] neg_o,
    output logic      [7:0] cur_o
);
    logic [2:0] code;

    ////////////////////////////////////////////////////////////////////////
    // Winding-aligned order, one or two sensors asserted at positions 0 to 5
    always_comb begin
        case (sel_i)
            3'h0: code = 3'h5;
            3'h1: code = 3'h4;
            3'h2: code = 3'h6;
            3'h3: code = 3'h2;
            3'h4: code = 3'h3;
            3'h5: code = 3'h1;
            3'h6: code = 3'h0;
            default: code = 3'h7;
        endcase
    end

    // Legs are complementary, so an idle sensor reads pos low, neg high
    always_ff @(posedge clk_i) begin
        pos_o <= code;
        neg_o <= ~code;
        cur_o <= load_i;
    end
endmodule

/* testbench.sv */
// Self-checking bench for the commutation controller.
// Assumes 20 MHz clock and the default carrier period of 800 cycles.
`timescale 1ns/1ps
module testbench;
    localparam logic [2:0] HCW [6] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h4, 3'h4};
    localparam logic [2:0] LCW [6] = '{3'h2, 3'h4, 3'h4, 3'h1, 3'h1, 3'h2};
    logic        clk   = 1'b0;
    logic        srst  = 1'b1;
    logic [3:0]  addr  = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic        wr    = 1'b0;
    logic        rd    = 1'b0;
    logic        run   = 1'b0;
    logic        dir   = 1'b1;
    logic        brk_n = 1'b1;
    logic [2:0]  sel   = 3'h0;
    logic [7:0]  load  = 8'h00;
    logic [15:0] rdata;
    logic [2:0]  pos, neg, hs, ls;
    logic [7:0]  cur;
    logic        fb;
    int          n_errors   = 0;
    int          num_checks = 0;

    // 50 ns period
    always #25 clk = ~clk;

    motor_ctrl_top motor_ctrl_top_inst (
        .SYS_CLK_I(clk), .SRST_I(srst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
        .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .RUN_STOP_I(run),
        .DIRECTION_SELECT_I(dir), .BRAKE_N_I(brk_n), .ROTOR_SENSOR_POSITIVE_I(pos),
        .ROTOR_SENSOR_NEGATIVE_I(neg), .SENSED_CURRENT_VOLTAGE_I(cur),
        .HIGH_SIDE_O(hs), .LOW_SIDE_O(ls), .SPEED_FEEDBACK_PULSE_O(fb));

    hall_motor_model hall_motor_model_inst (
        .clk_i(clk), .sel_i(sel), .load_i(load), .pos_o(pos), .neg_o(neg), .cur_o(cur));

    ////////////////////////////////////////////////////////////////////////
    // Verdict, compare and bus helpers
    task automatic print_verdict();
        $display("Checks %0d, errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_n(input int got, input int exp);
        num_checks++;
        if (got != exp) begin
            n_errors++;
            $display("MISMATCH at %0t: count %0d expected %0d", $time, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Data stand only in the cycle after the strobe edge
    task automatic reg_rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk);
        rd <= 1'b1; addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask

    // Pins cross a two-stage synchroniser, so allow a few edges to settle
    task automatic pins(input logic r, input logic d, input logic b, input logic [2:0] s);
        @(posedge clk);
        run <= r; dir <= d; brk_n <= b; sel <= s;
        repeat (6) @(posedge clk);
    endtask

    // One carrier period: high side, OR of low side, on cycles, low rises
    task automatic measure(output logic [2:0] h, output logic [2:0] lo, output int on,
                           output int rises);
        logic prev;
        lo = 3'h0; on = 0; rises = 0;
        // Seed the edge detector from a settled sample at the new duty
        @(posedge clk);
        #1 prev = (ls !== 3'h0);
        repeat (800) begin
            @(posedge clk);
            #1 h = hs;
            lo |= ls;
            if (ls !== 3'h0) on++;
            if (ls !== 3'h0 && !prev) rises++;
            prev = (ls !== 3'h0);
        end
    endtask

    // Step the rotor and time the feedback low phase, every wait bounded
    task automatic fb_low(input logic [2:0] s, output int n);
        int k, j;
        // Pulse level is read 1 ns after each edge, once it has settled
        for (k = 0; k < 25000 && fb !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        sel <= s;
        for (j = 0; j < 10 && fb !== 1'b0; j++) begin
            @(posedge clk);
            #1;
        end
        for (n = 0; n < 30000 && fb === 1'b0; n++) begin
            @(posedge clk);
            #1;
        end
        if (k == 25000 || j == 10 || n == 30000) begin
            n_errors++;
            print_verdict();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset();
        #1 chk({hs, ls, 9'h000, fb}, 16'h0001);
        reg_rd(motor_ctrl_pkg::SPEED_CMD_OFS, {8'h00, motor_ctrl_pkg::SPEED_CMD_RST});
        reg_rd(motor_ctrl_pkg::CUR_LIMIT_OFS, {8'h00, motor_ctrl_pkg::CUR_LIMIT_RST});
        reg_rd(motor_ctrl_pkg::LOW_TIME_OFS, motor_ctrl_pkg::LOW_TIME_RST);
        reg_wr(motor_ctrl_pkg::STATUS_OFS, 16'hFFFF);
        reg_rd(motor_ctrl_pkg::STATUS_OFS, 16'h000D);
        reg_rd(4'h2, 16'h0000);
    endtask

    task automatic t_commute();
        logic [2:0] h, lo;
        int on, r;
        reg_wr(motor_ctrl_pkg::SPEED_CMD_OFS, 16'h00FF);
        for (int d = 0; d < 2; d++) begin
            for (int i = 0; i < 6; i++) begin
                pins(1'b1, d[0], 1'b1, i[2:0]);
                measure(h, lo, on, r);
                chk(h, d ? HCW[i] : LCW[i]);
                chk(lo, d ? LCW[i] : HCW[i]);
            end
        end
    endtask

    task automatic t_off();
        logic [2:0] h, lo;
        int on, r;
        pins(1'b1, 1'b1, 1'b1, 3'h6);
        measure(h, lo, on, r);
        chk({h, lo}, 16'h0000);
        pins(1'b1, 1'b0, 1'b1, 3'h7);
        measure(h, lo, on, r);
        chk({h, lo}, 16'h0000);
        pins(1'b0, 1'b1, 1'b1, 3'h2);
        measure(h, lo, on, r);
        chk({h, lo}, 16'h0000);
    endtask

    task automatic t_brake();
        logic [2:0] h, lo;
        int on, r;
        pins(1'b0, 1'b1, 1'b0, 3'h7);
        measure(h, lo, on, r);
        chk({h, lo}, 16'h0007);
        pins(1'b1, 1'b0, 1'b0, 3'h3);
        measure(h, lo, on, r);
        chk({h, lo}, 16'h0007);
        chk_n(on, 800);
        // Run pin, brake and valid code 2 all visible at once
        reg_rd(motor_ctrl_pkg::STATUS_OFS, 16'h006A);
    endtask

    task automatic t_pwm();
        logic [2:0] h, lo;
        int on, r;
        pins(1'b1, 1'b1, 1'b1, 3'h0);
        foreach (HCW[i]) begin
            reg_wr(motor_ctrl_pkg::SPEED_CMD_OFS, 16'(i * 48));
            measure(h, lo, on, r);
            chk_n(on, (i * 48 * 800) >> 8);
            chk_n(r, i ? 1 : 0);
        end
    endtask

    task automatic t_limit();
        logic [2:0] h, lo;
        int on, r;
        reg_wr(motor_ctrl_pkg::SPEED_CMD_OFS, 16'h0080);
        reg_wr(motor_ctrl_pkg::CUR_LIMIT_OFS, 16'h0040);
        @(posedge clk) load <= 8'h41;
        repeat (6) @(posedge clk);
        measure(h, lo, on, r);
        chk_n(on, 0);
        chk(h, HCW[0]);
        // Over-limit flag set while the load sits above the limit
        reg_rd(motor_ctrl_pkg::STATUS_OFS, 16'h005D);
        @(posedge clk) load <= 8'h40;
        repeat (6) @(posedge clk);
        measure(h, lo, on, r);
        chk_n(on, 400);
    endtask

    task automatic t_feedback();
        int n, falls;
        logic prev;
        reg_wr(motor_ctrl_pkg::LOW_TIME_OFS, 16'h000A);
        fb_low(3'h1, n);
        chk_n(n, 1001);
        reg_wr(motor_ctrl_pkg::LOW_TIME_OFS, 16'h04B0);
        fb_low(3'h2, n);
        chk_n(n, 1200);
        falls = 0;
        prev = fb;
        // Steps 2401 cycles apart, so the 1200-cycle low time is just under half the period
        for (int i = 3; i < 9; i++) begin
            @(posedge clk) sel <= 3'(i % 6);
            repeat (2400) begin
                @(posedge clk);
                #1 if (prev === 1'b1 && fb === 1'b0) falls++;
                prev = fb;
            end
        end
        chk_n(falls, 6);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_commute();
        t_off();
        t_brake();
        t_pwm();
        t_limit();
        t_feedback();
        print_verdict();
    end
endmodule
